// ### rtl/irq_flag_pkg.sv
package irq_flag_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_FLAGS_A  = 8'h0C;
    localparam logic [7:0] ADDR_FLAGS_B  = 8'h0D;
    localparam logic [7:0] ADDR_IRQ_EN   = 8'h10; // enable word, 16 bits in two bytes
    localparam logic [7:0] ADDR_IRQ_ENH  = 8'h11;
    localparam logic [7:0] ADDR_IRQ_CTRL = 8'h12; // global / peripheral enable
    localparam logic [7:0] ADDR_CCP2_MODE = 8'h13;
    localparam logic [7:0] ADDR_U0_RX    = 8'h20;
    localparam logic [7:0] ADDR_U0_TX    = 8'h21;
    localparam logic [7:0] ADDR_U1_RX    = 8'h22;
    localparam logic [7:0] ADDR_U1_TX    = 8'h23;

    localparam logic [7:0] FLAGS_RESET   = 8'h00;
    localparam logic [7:0] ZERO_BYTE     = 8'h00;

    // ****************************************
    // field positions
    // ****************************************
    localparam int A_CONV   = 6;
    localparam int A_U0RX   = 5;
    localparam int A_U0TX   = 4;
    localparam int A_PWM    = 2;
    localparam int A_T2MATCH = 1;
    localparam int A_T1OVF   = 0;
    localparam int B_LOWV    = 7;
    localparam int B_EE     = 4;
    localparam int B_BCOL   = 3;
    localparam int B_U1TX   = 2;
    localparam int B_U1RX   = 1;
    localparam int B_CCP2   = 0;
    localparam int CTL_GLOBAL = 0;
    localparam int CTL_PERIPH = 1;

    // implemented bits of each flag register
    localparam logic [7:0] MASK_A = 8'h77;
    localparam logic [7:0] MASK_B = 8'h9F;

    // capture/compare unit 2 modes
    localparam logic [1:0] CCP_OFF     = 2'h0;
    localparam logic [1:0] CCP_CAPTURE = 2'h1;
    localparam logic [1:0] CCP_COMPARE = 2'h2;
    localparam logic [1:0] CCP_PWM     = 2'h3;

    typedef struct packed {
        logic convDone;
        logic pwmPeriod;
        logic timer2Match;
        logic timer1Overflow;
        logic lowVoltage;
        logic eepromDone;
        logic busCollision;
        logic i2cMaster;
        logic ccp2Capture;
        logic ccp2Compare;
        logic uart0RxFull;
        logic uart0TxEmpty;
        logic uart1RxFull;
        logic uart1TxEmpty;
    } events_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } regbus_t;

endpackage

// ### rtl/peripheral_irq_flag_bank.sv
// Notes on behaviour
// R1: flags set regardless of enable bits
// R2: software clears flag before enabling it
// R3: conversion done sets bit6, software clears
// R4: uart0 rx flag follows buffer, read clears
// R5: uart0 tx flag on empty, write clears
// R6: pwm period sets bit2, software clears
// R7: timer2 period match sets bit1
// R8: timer1 overflow sets bit0, software clears
// R9: low voltage event sets second bit7
// R10: i2c master collision sets second bit3
// R11: uart1 tx flag on empty, write clears
// R12: uart1 rx flag while full, read clears
// R13: capture mode capture sets second bit0
// R14: compare mode match sets second bit0
// R15: pwm mode never sets ccp2 flag
// R16: request needs flag, enable, both enables
// R17: eeprom write complete sets second bit4
// R18: hardware set beats same-cycle software clear
//
// The implementer's own choice: the plain strobed port.
module peripheral_irq_flag_bank (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire irq_flag_pkg::regbus_t bus,
    input  wire irq_flag_pkg::events_t events,
    output logic [7:0]                 rdata,
    output logic                       irqReq,
    output logic                       uart0RxRead,
    output logic                       uart0TxWrite,
    output logic                       uart1RxRead,
    output logic                       uart1TxWrite
);
    import irq_flag_pkg::*;

    logic [7:0]  flagsA_q;
    logic [7:0]  flagsB_q;
    logic [7:0]  flagsA_d;
    logic [7:0]  flagsB_d;
    logic [7:0]  setA;
    logic [7:0]  setB;
    logic [15:0] enable_q;
    logic [1:0]  ctrl_q;
    logic [1:0]  ccpMode_q;
    logic        ccp2Event;

    // ****************************************
    // address decode helper
    // ****************************************
    function automatic logic hit(input regbus_t b, input logic [7:0] a, input logic wr);
        hit = (b.addr == a) && (wr ? b.wr : b.rd);
    endfunction

    // ****************************************
    // hardware set terms
    // ****************************************
    // ccp2 flag source chosen by mode; pwm mode leaves it untouched
    always_comb begin
        unique case (ccpMode_q)
            CCP_CAPTURE: ccp2Event = events.ccp2Capture; // [R13]
            CCP_COMPARE: ccp2Event = events.ccp2Compare; // [R14]
            CCP_PWM:     ccp2Event = 1'b0;               // [R15]
            CCP_OFF:     ccp2Event = 1'b0;
        endcase
    end

    // event sets ignore every enable bit
    always_comb begin
        setA = ZERO_BYTE;
        setB = ZERO_BYTE;
        setA[A_CONV] = events.convDone;           // [R1] [R3]
        setA[A_PWM]  = events.pwmPeriod;          // [R6]
        setA[A_T2MATCH] = events.timer2Match;     // [R7]
        setA[A_T1OVF]   = events.timer1Overflow;  // [R8]
        setB[B_LOWV]    = events.lowVoltage;      // [R9]
        setB[B_EE]   = events.eepromDone;         // [R17]
        setB[B_BCOL] = events.busCollision && events.i2cMaster; // [R10]
        setB[B_CCP2] = ccp2Event;
    end

    // ****************************************
    // flag next state
    // ****************************************
    // software write first, then sets on top so no event is lost
    always_comb begin
        flagsA_d = flagsA_q;
        flagsB_d = flagsB_q;
        if (hit(bus, ADDR_FLAGS_A, 1'b1)) begin
            flagsA_d = bus.wdata & MASK_A;
        end
        if (hit(bus, ADDR_FLAGS_B, 1'b1)) begin
            flagsB_d = bus.wdata & MASK_B;
        end
        flagsA_d = flagsA_d | setA; // [R18]
        flagsB_d = flagsB_d | setB; // [R18]
        // buffer-state flags mirror their peripheral's buffer level
        flagsA_d[A_U0RX] = events.uart0RxFull;  // [R4]
        flagsA_d[A_U0TX] = events.uart0TxEmpty; // [R5]
        flagsB_d[B_U1TX] = events.uart1TxEmpty; // [R11]
        flagsB_d[B_U1RX] = events.uart1RxFull;  // [R12]
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flagsA_q <= FLAGS_RESET;
            flagsB_q <= FLAGS_RESET;
        end else begin
            flagsA_q <= flagsA_d;
            flagsB_q <= flagsB_d;
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    // enables only gate the request, never the flags
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            enable_q  <= {FLAGS_RESET, FLAGS_RESET};
            ctrl_q    <= CCP_OFF;
            ccpMode_q <= CCP_OFF;
        end else begin
            if (hit(bus, ADDR_IRQ_EN, 1'b1)) begin
                enable_q[7:0] <= bus.wdata & MASK_A;
            end
            if (hit(bus, ADDR_IRQ_ENH, 1'b1)) begin
                enable_q[15:8] <= bus.wdata & MASK_B;
            end
            if (hit(bus, ADDR_IRQ_CTRL, 1'b1)) begin
                ctrl_q <= bus.wdata[1:0];
            end
            if (hit(bus, ADDR_CCP2_MODE, 1'b1)) begin
                ccpMode_q <= bus.wdata[1:0];
            end
        end
    end

    // ****************************************
    // read data, side-effect strobes, request
    // ****************************************
    // uart data strobes tell the uart to empty/fill its buffer; flag follows
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata        <= ZERO_BYTE;
            irqReq       <= 1'b0;
            uart0RxRead  <= 1'b0;
            uart0TxWrite <= 1'b0;
            uart1RxRead  <= 1'b0;
            uart1TxWrite <= 1'b0;
        end else begin
            uart0RxRead  <= hit(bus, ADDR_U0_RX, 1'b0); // [R4]
            uart0TxWrite <= hit(bus, ADDR_U0_TX, 1'b1); // [R5]
            uart1RxRead  <= hit(bus, ADDR_U1_RX, 1'b0); // [R12]
            uart1TxWrite <= hit(bus, ADDR_U1_TX, 1'b1); // [R11]
            // stale events stay visible; software must clear before enabling
            irqReq <= ctrl_q[CTL_GLOBAL] && ctrl_q[CTL_PERIPH]
                      && (|({flagsB_q, flagsA_q} & enable_q)); // [R16]
            if (bus.rd) begin
                unique case (bus.addr)
                    ADDR_FLAGS_A:   rdata <= flagsA_q;
                    ADDR_FLAGS_B:   rdata <= flagsB_q;
                    ADDR_IRQ_EN:    rdata <= enable_q[7:0];
                    ADDR_IRQ_ENH:   rdata <= enable_q[15:8];
                    ADDR_IRQ_CTRL:  rdata <= {6'h00, ctrl_q};
                    ADDR_CCP2_MODE: rdata <= {6'h00, ccpMode_q};
                    default:        rdata <= ZERO_BYTE;
                endcase
            end else begin
                rdata <= ZERO_BYTE;
            end
        end
    end

endmodule

// ### verification/flag_bank_assertions.sv
module flag_bank_checker (
    input wire logic                  clk,
    input wire logic                  reset_n,
    input wire irq_flag_pkg::regbus_t bus,
    input wire irq_flag_pkg::events_t events,
    input wire logic [7:0]            rdata,
    input wire logic                  irqReq,
    input wire logic                  uart0RxRead,
    input wire logic                  uart0TxWrite,
    input wire logic                  uart1RxRead,
    input wire logic                  uart1TxWrite
);
    timeunit 1ns;
    timeprecision 1ps;
    import irq_flag_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // flag reads, decoded once
    wire rdA = bus.rd && bus.addr == ADDR_FLAGS_A;
    wire rdB = bus.rd && bus.addr == ADDR_FLAGS_B;
    u0rx_strobe_a: assert property (bus.rd && bus.addr == ADDR_U0_RX |=> uart0RxRead)
        else $error("uart0 read strobe missing");
    u0tx_strobe_a: assert property (bus.wr && bus.addr == ADDR_U0_TX |=> uart0TxWrite)
        else $error("uart0 write strobe missing");
    u1rx_strobe_a: assert property (bus.rd && bus.addr == ADDR_U1_RX |=> uart1RxRead)
        else $error("uart1 read strobe missing");
    u1tx_strobe_a: assert property (bus.wr && bus.addr == ADDR_U1_TX |=> uart1TxWrite)
        else $error("uart1 write strobe missing");
    conv_set_a: assert property (events.convDone ##1 rdA |=> rdata[A_CONV])
        else $error("conversion flag not set");
    // mirrors lag the buffer status by one cycle, read data by one more
    mirror_a_a: assert property (rdA |=> {rdata[A_U0RX], rdata[A_U0TX]} ==
        $past({events.uart0RxFull, events.uart0TxEmpty}, 2)) else $error("uart0 mirror wrong");
    mirror_b_a: assert property (rdB |=> {rdata[B_U1RX], rdata[B_U1TX]} ==
        $past({events.uart1RxFull, events.uart1TxEmpty}, 2)) else $error("uart1 mirror wrong");
    irq_off_a: assert property (bus.wr && bus.addr == ADDR_IRQ_CTRL && bus.wdata == 8'h00
        |=> ##1 !irqReq) else $error("request with enables off");
    cover property (irqReq);
    cover property (events.convDone ##1 rdA);
    cover property (uart1RxRead);
endmodule

bind peripheral_irq_flag_bank flag_bank_checker watch (.clk(clk), .reset_n(reset_n), .bus(bus),
    .events(events), .rdata(rdata), .irqReq(irqReq), .uart0RxRead(uart0RxRead),
    .uart0TxWrite(uart0TxWrite), .uart1RxRead(uart1RxRead), .uart1TxWrite(uart1TxWrite));

// ### verification/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import irq_flag_pkg::*;
    logic       clk = 0, reset_n = 0, irqReq;
    regbus_t    bus = '0;
    events_t    evIn = 14'h0040, events; // bus master mode held on
    logic [7:0] rdata, got, a;
    wire  [1:0] rxRd, txWr, rxFull, txEmpty;
    logic [1:0] arrive = 0, sent = 0;
    int         fails = 0, compares = 0, cyc = 0, seed = 32'hf5b8;
    int         ev[10] = '{13, 12, 11, 10, 9, 8, 7, 5, 4, 4};
    int         fb[10] = '{A_CONV, A_PWM, A_T2MATCH, A_T1OVF, B_LOWV, B_EE, B_BCOL, 0, 0, 0};
    logic [1:0] md[10] = '{0, 0, 0, 0, 0, 0, 0, CCP_CAPTURE, CCP_COMPARE, CCP_PWM};
    assign events = {evIn[13:4], rxFull[0], txEmpty[0], rxFull[1], txEmpty[1]};
    peripheral_irq_flag_bank DUT (.clk(clk), .reset_n(reset_n), .bus(bus), .events(events),
        .rdata(rdata), .irqReq(irqReq), .uart0RxRead(rxRd[0]), .uart0TxWrite(txWr[0]),
        .uart1RxRead(rxRd[1]), .uart1TxWrite(txWr[1]));
    uart_buffer_model far (.clk(clk), .reset_n(reset_n), .arrive(arrive), .sent(sent),
        .rxRead(rxRd), .txWrite(txWr), .rxFull_q(rxFull), .txEmpty_q(txEmpty));
    // clock and a hang limit well past the run length
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            end_sim;
        end
    end
    function logic [7:0] expect_flag(int b, logic [1:0] m);
        return (m == CCP_PWM) ? ZERO_BYTE : 8'h01 << b;
    endfunction
    task chk(string what, logic [7:0] seen, logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(logic [7:0] ad, logic [7:0] d);
        @(posedge clk) bus <= '{ad, d, 1'b1, 1'b0};
        @(posedge clk) bus <= '0;
    endtask
    task rd(logic [7:0] ad);
        @(posedge clk) bus <= '{ad, 8'h00, 1'b0, 1'b1};
        @(posedge clk) bus <= '0;
        #1 got = rdata;
    endtask
    task end_sim;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // event table, random enables show flags set regardless
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        rd(ADDR_FLAGS_A);
        chk("flags a reset", got, FLAGS_RESET);
        rd(8'h3F);
        chk("unmapped", got, ZERO_BYTE);
        for (int i = 0; i < 10; i++) begin
            a = (i < 4) ? ADDR_FLAGS_A : ADDR_FLAGS_B;
            wr(ADDR_CCP2_MODE, {6'h00, md[i]});
            wr(ADDR_IRQ_EN, 8'($random(seed)));
            @(posedge clk) evIn[ev[i]] <= 1'b1;
            @(posedge clk) evIn[ev[i]] <= 1'b0;
            rd(a);
            chk("flag set", got, expect_flag(fb[i], md[i]));
            wr(a, ZERO_BYTE);
            rd(a);
            chk("flag cleared", got, ZERO_BYTE);
        end
        wr(ADDR_FLAGS_B, ZERO_BYTE);
        wr(ADDR_IRQ_EN, 8'hFF);
        wr(ADDR_IRQ_CTRL, 8'h03);
        @(posedge clk);
        bus <= '{ADDR_FLAGS_A, ZERO_BYTE, 1'b1, 1'b0};
        evIn[13] <= 1'b1;
        @(posedge clk);
        bus <= '0;
        evIn[13] <= 1'b0;
        rd(ADDR_FLAGS_A);
        chk("set beats clear", got, 8'h40);
        chk("request", {7'h00, irqReq}, 8'h01);
        wr(ADDR_IRQ_CTRL, ZERO_BYTE);
        @(posedge clk) #1 chk("request off", {7'h00, irqReq}, 8'h00);
        wr(ADDR_FLAGS_A, ZERO_BYTE);
        // byte arrives and transmitter drains, then cpu services both
        for (int u = 0; u < 2; u++) begin
            a = u ? ADDR_FLAGS_B : ADDR_FLAGS_A;
            @(posedge clk) {arrive[u], sent[u]} <= 2'b11;
            @(posedge clk) {arrive, sent} <= 4'h0;
            rd(a);
            chk("uart flags", got, u ? 8'h06 : 8'h30);
            wr(ADDR_U0_TX + 8'(2 * u), 8'($random(seed)));
            rd(ADDR_U0_RX + 8'(2 * u));
            repeat (3) @(posedge clk);
            rd(a);
            chk("uart flags cleared", got, ZERO_BYTE);
        end
        end_sim;
    end
endmodule

// ### verification/uart_buffer_model.sv
module uart_buffer_model (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [1:0] arrive,
    input  wire logic [1:0] sent,
    input  wire logic [1:0] rxRead,
    input  wire logic [1:0] txWrite,
    output logic [1:0]      rxFull_q,
    output logic [1:0]      txEmpty_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // receive byte held until the cpu reads it
    always_ff @(posedge clk) begin
        if (!reset_n) rxFull_q <= 2'b00;
        else rxFull_q <= (rxFull_q & ~rxRead) | arrive;
    end
    // shifter counts as busy after reset, so tx flags start clear
    always_ff @(posedge clk) begin
        if (!reset_n) txEmpty_q <= 2'b00;
        else txEmpty_q <= (txEmpty_q & ~txWrite) | sent;
    end
endmodule
